// ### verilog/ulp_pkg.sv
// constants and types for the uart low-power controller
`default_nettype none
package ulp_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] A_TXH = 4'h0;
  localparam logic [3:0] A_INTEN = 4'h1;
  localparam logic [3:0] A_INTSRC = 4'h2;
  localparam logic [3:0] A_DIVL = 4'h3;
  localparam logic [3:0] A_DIVH = 4'h4;
  localparam logic [3:0] A_MDMST = 4'h6;
  localparam logic [3:0] A_EVT = 4'h8;
  localparam logic [3:0] A_MASK = 4'h9;
  localparam logic [3:0] A_PWR = 4'ha;

  // field positions
  localparam int INTEN_SLEEP_BIT = 4;
  localparam int MDM_DELTA_W = 4;
  localparam logic [3:0] WAKE_CODE = 4'h1;

  // event status bits
  localparam int EV_SLEEP = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_PUMP_OFF = 2;
  localparam int EV_PUMP_ON = 3;
  localparam int EV_ISOLATE = 4;
  localparam int EV_W = 5;

  // power status bits
  localparam int PW_SLEEP = 0;
  localparam int PW_ISO = 1;
  localparam int PW_PUMP_ON = 2;
  localparam int PW_PUMP_RDY = 3;
  localparam int PW_WAKE_FLAG = 4;

  // reset values
  localparam logic [7:0] INTEN_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  // timing
  localparam logic [63:0] CLK_HZ = 64'd125_000_000;
  localparam logic [63:0] NS_PER_S = 64'd1_000_000_000;
  localparam logic [63:0] PUMP_IDLE_S = 64'd30;
  localparam logic [63:0] IDLE_CYC = PUMP_IDLE_S * CLK_HZ;
  localparam logic [63:0] PUMP_START_NS = 64'd45_000;
  localparam logic [63:0] PUMP_CYC = (PUMP_START_NS * CLK_HZ + NS_PER_S - 64'd1) / NS_PER_S;
  localparam logic [63:0] OSC_SETTLE_NS = 64'd1_000;
  localparam logic [63:0] OSC_CYC = (OSC_SETTLE_NS * CLK_HZ + NS_PER_S - 64'd1) / NS_PER_S;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ulp_req_s;

  typedef enum logic [1:0] {SL_ACTIVE, SL_SLEEP, SL_WAKING} ulp_sleep_e;
  typedef enum logic [1:0] {PU_ON, PU_OFF, PU_START} ulp_pump_e;
endpackage
`default_nettype wire

// ### verilog/ulp_top.sv
// uart sleep, charge-pump shutdown and bus-isolation controller
//
// Summary of operation
// RQ1 - sleep only when idle, enabled, divisor nonzero
// RQ2 - oscillator stopped while asleep
// RQ3 - wake on start bit, transmit load, modem
// RQ4 - wake raises code 0x1, source read clears
// RQ5 - resleep automatically, never with interrupt pending
// RQ6 - modem status read clears change indications
// RQ7 - sleep persists until enable bit cleared
// RQ8 - awake pump off after 30 s idle
// RQ9 - pump off: drivers tristate, registers reachable
// RQ10 - pump restarts on rx, transmit, modem rise
// RQ11 - host waits 45 us before transmitting
// RQ12 - asleep with auto shutdown: pump off immediately
// RQ13 - isolate pin while asleep isolates bus
// RQ14 - power-save wakes only on rx or modem
// RQ15 - power-save reenters; exits on enable or pin
// RQ16 - wake interrupt only after oscillator ready
// RQ17 - core held idle until oscillator stable
`default_nettype none
module ulp_top #(
  parameter int RX_CH = 2,
  parameter int MODEM_W = 4,
  parameter logic [31:0] IDLE_CYCLES = 32'(ulp_pkg::IDLE_CYC),
  parameter logic [15:0] PUMP_CYCLES = 16'(ulp_pkg::PUMP_CYC),
  parameter logic [15:0] OSC_CYCLES = 16'(ulp_pkg::OSC_CYC)
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire ulp_pkg::ulp_req_s bus_in,
  output logic [ulp_pkg::DATA_W-1:0] rdata_out,
  output logic irq_out,
  // serial and modem pins
  input wire logic [RX_CH-1:0] rx_in,
  input wire logic [MODEM_W-1:0] modem_in,
  input wire logic auto_pump_shutdown_pin_in,
  input wire logic bus_isolate_pin_in,
  // oscillator
  input wire logic osc_ready_in,
  output logic crystal_out_pin_en_out,
  output logic core_hold_out,
  // uart core status, same clock
  input wire logic tx_active_in,
  input wire logic uart_int_pending_in,
  input wire logic [3:0] uart_int_code_in,
  // transceiver and power status
  output logic pump_on_out,
  output logic pump_ready_out,
  output logic rs485_drv_en_out,
  output logic bus_isolated_out,
  output logic sleeping_out
);
  localparam int NS = RX_CH + MODEM_W + 3;
  localparam int P_MOD = RX_CH;
  localparam int P_APS = RX_CH + MODEM_W;
  localparam int P_ISO = P_APS + 1;
  localparam int P_OSC = P_APS + 2;
  // stages start at each pin's idle level, so release of reset shows no edge
  localparam logic [NS-1:0] SYNC_RST = {1'b1, 1'b0, 1'b0, {MODEM_W{1'b0}}, {RX_CH{1'b1}}};

  // synchronisers; third stage only feeds edge detection
  logic [NS-1:0] s1_reg, s2_reg, s3_reg;
  logic [NS-1:0] s1_next, s2_next, s3_next;

  always_comb begin
    s1_next = {osc_ready_in, bus_isolate_pin_in, auto_pump_shutdown_pin_in, modem_in, rx_in};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
      s3_reg <= SYNC_RST;
    end else if (ce_in) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  logic [RX_CH-1:0] rx_now, rx_old;
  logic [MODEM_W-1:0] mod_now, mod_old;
  logic rx_fall, rx_rise, modem_chg, modem_rise, rx_idle;
  logic aps, iso_pin, osc_rdy;

  always_comb begin
    rx_now = s2_reg[RX_CH-1:0];
    rx_old = s3_reg[RX_CH-1:0];
    mod_now = s2_reg[P_MOD +: MODEM_W];
    mod_old = s3_reg[P_MOD +: MODEM_W];
    rx_fall = |(rx_old & ~rx_now);
    rx_rise = |(~rx_old & rx_now);
    modem_chg = |(mod_old ^ mod_now);
    modem_rise = |(~mod_old & mod_now);
    rx_idle = &rx_now;
    aps = s2_reg[P_APS];
    iso_pin = s2_reg[P_ISO];
    osc_rdy = s2_reg[P_OSC];
  end

  // register file state
  logic [7:0] inten_reg, inten_next, divl_reg, divl_next, divh_reg, divh_next;
  logic [ulp_pkg::MDM_DELTA_W-1:0] delta_reg, delta_next;
  logic wake_flag_reg, wake_flag_next;
  logic [ulp_pkg::EV_W-1:0] evt_reg, evt_next, mask_reg, mask_next, ev_set;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  // sleep state
  ulp_pkg::ulp_sleep_e sl_reg, sl_next;
  logic [15:0] osc_cnt_reg, osc_cnt_next;
  logic armed_reg, armed_next;
  logic iso_reg, iso_next, hold_reg, hold_next, osc_run_reg, osc_run_next;
  logic slp_reg, slp_next;

  // pump state
  ulp_pkg::ulp_pump_e pu_reg, pu_next;
  logic [31:0] idle_cnt_reg, idle_cnt_next;
  logic [15:0] pu_cnt_reg, pu_cnt_next;
  logic drv_en_reg, drv_en_next;
  logic pon_reg, pon_next;

  logic wr_ok, rd_ok, txh_wr, pending, sleep_ok, wake_evt, wake_done;
  logic [3:0] src_code;
  logic [7:0] pwr_stat;

  always_comb begin
    // bus inputs are ignored while isolated, so bus noise cannot wake us
    wr_ok = bus_in.wr & ~iso_reg; // see RQ13 see RQ14
    rd_ok = bus_in.rd & ~iso_reg;
    txh_wr = wr_ok && (bus_in.addr == ulp_pkg::A_TXH);
    pending = uart_int_pending_in | wake_flag_reg;
    sleep_ok = inten_reg[ulp_pkg::INTEN_SLEEP_BIT] & ~pending
               & ({divh_reg, divl_reg} != 16'h0000)
               & (delta_reg == '0) & rx_idle; // see RQ1 see RQ5
    wake_evt = rx_fall | txh_wr | modem_chg
               | ~inten_reg[ulp_pkg::INTEN_SLEEP_BIT]; // see RQ3 see RQ7
    wake_done = (sl_reg == ulp_pkg::SL_WAKING) && osc_rdy && (osc_cnt_reg >= OSC_CYCLES - 16'h1);
    // wake code shares 0x1 with no-pending, so it shows only when nothing else is
    src_code = uart_int_pending_in ? uart_int_code_in : ulp_pkg::WAKE_CODE; // see RQ4 see RQ16
    pwr_stat = '0;
    pwr_stat[ulp_pkg::PW_SLEEP] = (sl_reg == ulp_pkg::SL_SLEEP);
    pwr_stat[ulp_pkg::PW_ISO] = iso_reg;
    pwr_stat[ulp_pkg::PW_PUMP_ON] = (pu_reg != ulp_pkg::PU_OFF);
    pwr_stat[ulp_pkg::PW_PUMP_RDY] = (pu_reg == ulp_pkg::PU_ON);
    pwr_stat[ulp_pkg::PW_WAKE_FLAG] = wake_flag_reg;
  end

  // sleep state machine
  always_comb begin
    sl_next = sl_reg;
    osc_cnt_next = osc_cnt_reg;
    armed_next = armed_reg;
    case (sl_reg)
      ulp_pkg::SL_ACTIVE: begin
        if (sleep_ok) begin
          sl_next = ulp_pkg::SL_SLEEP;
          armed_next = 1'b1;
        end
      end
      ulp_pkg::SL_SLEEP: begin
        if (wake_evt) begin
          sl_next = ulp_pkg::SL_WAKING;
          osc_cnt_next = '0;
          armed_next = inten_reg[ulp_pkg::INTEN_SLEEP_BIT];
        end
      end
      ulp_pkg::SL_WAKING: begin
        if (osc_cnt_reg < OSC_CYCLES) begin
          osc_cnt_next = osc_cnt_reg + 16'h1;
        end
        if (wake_done) begin
          sl_next = ulp_pkg::SL_ACTIVE; // see RQ17
        end
      end
      default: begin
        sl_next = ulp_pkg::SL_ACTIVE;
      end
    endcase
    osc_run_next = (sl_next != ulp_pkg::SL_SLEEP); // see RQ2
    hold_next = (sl_next != ulp_pkg::SL_ACTIVE); // see RQ17
    iso_next = (sl_next == ulp_pkg::SL_SLEEP) & iso_pin
               & inten_reg[ulp_pkg::INTEN_SLEEP_BIT]; // see RQ13 see RQ15
    slp_next = (sl_next == ulp_pkg::SL_SLEEP);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sl_reg <= ulp_pkg::SL_ACTIVE;
      osc_cnt_reg <= '0;
      armed_reg <= 1'b0;
      osc_run_reg <= 1'b1;
      hold_reg <= 1'b0;
      iso_reg <= 1'b0;
      slp_reg <= 1'b0;
    end else if (ce_in) begin
      sl_reg <= sl_next;
      osc_cnt_reg <= osc_cnt_next;
      armed_reg <= armed_next;
      osc_run_reg <= osc_run_next;
      hold_reg <= hold_next;
      iso_reg <= iso_next;
      slp_reg <= slp_next;
    end
  end

  // charge pump state machine
  always_comb begin
    pu_next = pu_reg;
    pu_cnt_next = pu_cnt_reg;
    idle_cnt_next = '0;
    case (pu_reg)
      ulp_pkg::PU_ON: begin
        if (aps && sl_reg == ulp_pkg::SL_SLEEP) begin
          pu_next = ulp_pkg::PU_OFF; // see RQ12
        end else if (aps && sl_reg == ulp_pkg::SL_ACTIVE && !tx_active_in && !modem_chg) begin
          idle_cnt_next = idle_cnt_reg + 32'h1;
          if (idle_cnt_reg >= IDLE_CYCLES - 32'h1) begin
            pu_next = ulp_pkg::PU_OFF; // see RQ8
          end
        end
      end
      ulp_pkg::PU_OFF: begin
        if (rx_rise || txh_wr || modem_rise || !aps) begin
          pu_next = ulp_pkg::PU_START; // see RQ10
          pu_cnt_next = '0;
        end
      end
      ulp_pkg::PU_START: begin
        // drivers stay off through start-up; the host should also wait
        pu_cnt_next = pu_cnt_reg + 16'h1;
        if (pu_cnt_reg >= PUMP_CYCLES - 16'h1) begin
          pu_next = ulp_pkg::PU_ON; // see RQ11
        end
      end
      default: begin
        pu_next = ulp_pkg::PU_ON;
      end
    endcase
    drv_en_next = (pu_next == ulp_pkg::PU_ON); // see RQ9
    pon_next = (pu_next != ulp_pkg::PU_OFF);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pu_reg <= ulp_pkg::PU_ON;
      pu_cnt_reg <= '0;
      idle_cnt_reg <= '0;
      drv_en_reg <= 1'b1;
      pon_reg <= 1'b1;
    end else if (ce_in) begin
      pu_reg <= pu_next;
      pu_cnt_reg <= pu_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
      drv_en_reg <= drv_en_next;
      pon_reg <= pon_next;
    end
  end

  // registers, flags and read data
  always_comb begin
    inten_next = inten_reg;
    divl_next = divl_reg;
    divh_next = divh_reg;
    mask_next = mask_reg;
    delta_next = delta_reg;
    wake_flag_next = wake_flag_reg;
    evt_next = evt_reg;
    rdata_next = '0;
    ev_set = '0;
    ev_set[ulp_pkg::EV_SLEEP] = (sl_reg == ulp_pkg::SL_ACTIVE) && (sl_next == ulp_pkg::SL_SLEEP);
    ev_set[ulp_pkg::EV_WAKE] = wake_done;
    ev_set[ulp_pkg::EV_PUMP_OFF] = (pu_reg != ulp_pkg::PU_OFF) && (pu_next == ulp_pkg::PU_OFF);
    ev_set[ulp_pkg::EV_PUMP_ON] = (pu_reg == ulp_pkg::PU_START) && (pu_next == ulp_pkg::PU_ON);
    ev_set[ulp_pkg::EV_ISOLATE] = iso_next & ~iso_reg;
    if (wr_ok) begin
      if (bus_in.addr == ulp_pkg::A_INTEN) begin
        inten_next = bus_in.wdata; // see RQ7
      end else if (bus_in.addr == ulp_pkg::A_DIVL) begin
        divl_next = bus_in.wdata;
      end else if (bus_in.addr == ulp_pkg::A_DIVH) begin
        divh_next = bus_in.wdata;
      end else if (bus_in.addr == ulp_pkg::A_EVT) begin
        evt_next = evt_reg & ~bus_in.wdata[ulp_pkg::EV_W-1:0];
      end else if (bus_in.addr == ulp_pkg::A_MASK) begin
        mask_next = bus_in.wdata[ulp_pkg::EV_W-1:0];
      end
    end
    if (rd_ok) begin
      if (bus_in.addr == ulp_pkg::A_INTEN) begin
        rdata_next = inten_reg;
      end else if (bus_in.addr == ulp_pkg::A_INTSRC) begin
        rdata_next = {4'h0, src_code};
        wake_flag_next = 1'b0; // see RQ4 see RQ16
      end else if (bus_in.addr == ulp_pkg::A_DIVL) begin
        rdata_next = divl_reg;
      end else if (bus_in.addr == ulp_pkg::A_DIVH) begin
        rdata_next = divh_reg;
      end else if (bus_in.addr == ulp_pkg::A_MDMST) begin
        rdata_next = {mod_now, delta_reg};
        delta_next = '0; // see RQ6
      end else if (bus_in.addr == ulp_pkg::A_EVT) begin
        rdata_next = {3'h0, evt_reg};
      end else if (bus_in.addr == ulp_pkg::A_MASK) begin
        rdata_next = {3'h0, mask_reg};
      end else if (bus_in.addr == ulp_pkg::A_PWR) begin
        rdata_next = pwr_stat;
      end
    end
    // hardware sets win over same-cycle clears
    delta_next = delta_next | (mod_old ^ mod_now); // see RQ3
    if (wake_done && armed_reg) begin
      wake_flag_next = 1'b1; // see RQ16
    end
    evt_next = evt_next | ev_set;
    irq_next = |(evt_reg & mask_reg);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      inten_reg <= ulp_pkg::INTEN_RST;
      divl_reg <= ulp_pkg::DIV_RST;
      divh_reg <= ulp_pkg::DIV_RST;
      mask_reg <= ulp_pkg::MASK_RST;
      delta_reg <= '0;
      wake_flag_reg <= 1'b0;
      evt_reg <= '0;
      rdata_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce_in) begin
      inten_reg <= inten_next;
      divl_reg <= divl_next;
      divh_reg <= divh_next;
      mask_reg <= mask_next;
      delta_reg <= delta_next;
      wake_flag_reg <= wake_flag_next;
      evt_reg <= evt_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign irq_out = irq_reg;
  assign crystal_out_pin_en_out = osc_run_reg;
  assign core_hold_out = hold_reg;
  assign pump_on_out = pon_reg;
  // ready and driver enable are the same condition, so one flop serves both
  assign pump_ready_out = drv_en_reg;
  assign rs485_drv_en_out = drv_en_reg;
  assign bus_isolated_out = iso_reg;
  assign sleeping_out = slp_reg;
endmodule
`default_nettype wire

// ### bench/ulp_asserts.sv
// concurrent checks on the ports of the low-power controller
`default_nettype none
module ulp_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // inputs watched
  input wire ulp_pkg::ulp_req_s bus_in,
  input wire logic uart_int_pending_in,
  input wire logic auto_pump_shutdown_pin_in,
  // outputs watched
  input wire logic [ulp_pkg::DATA_W-1:0] rdata_out,
  input wire logic crystal_out_pin_en_out,
  input wire logic core_hold_out,
  input wire logic pump_on_out,
  input wire logic pump_ready_out,
  input wire logic rs485_drv_en_out,
  input wire logic bus_isolated_out,
  input wire logic sleeping_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_osc; sleeping_out |-> !crystal_out_pin_en_out; endproperty
  a_osc: assert property (p_osc) else $error("oscillator runs in sleep");
  property p_pend; uart_int_pending_in && !sleeping_out |=> !sleeping_out; endproperty
  a_pend: assert property (p_pend) else $error("slept with interrupt pending");
  property p_thr;
    sleeping_out && !bus_isolated_out && bus_in.wr && bus_in.addr == ulp_pkg::A_TXH
      |-> ##[1:3] !sleeping_out;
  endproperty
  a_thr: assert property (p_thr) else $error("transmit load did not wake");
  property p_drv; !pump_on_out |=> !rs485_drv_en_out; endproperty
  a_drv: assert property (p_drv) else $error("drivers on with pump off");
  property p_start; $rose(pump_on_out) |-> !pump_ready_out [*4]; endproperty
  a_start: assert property (p_start) else $error("pump ready too early");
  property p_acp; (sleeping_out && auto_pump_shutdown_pin_in) [*6] |-> !pump_ready_out;
  endproperty
  a_acp: assert property (p_acp) else $error("pump kept on in sleep");
  property p_iso; $rose(bus_isolated_out) |-> sleeping_out; endproperty
  a_iso: assert property (p_iso) else $error("isolated while awake");
  property p_rd; bus_isolated_out || !bus_in.rd |=> rdata_out == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside read slot");
  property p_ps;
    sleeping_out && bus_isolated_out && bus_in.wr && bus_in.addr == ulp_pkg::A_TXH
      |=> sleeping_out;
  endproperty
  a_ps: assert property (p_ps) else $error("bus woke power-save");
  property p_hold; $fell(core_hold_out) |-> $past(crystal_out_pin_en_out, 3); endproperty
  a_hold: assert property (p_hold) else $error("core released before settle");
endmodule
bind ulp_top ulp_asserts u_asserts (.clk_in, .rst_in, .bus_in, .uart_int_pending_in,
  .auto_pump_shutdown_pin_in, .rdata_out, .crystal_out_pin_en_out, .core_hold_out,
  .pump_on_out, .pump_ready_out, .rs485_drv_en_out, .bus_isolated_out, .sleeping_out);
`default_nettype wire

// ### bench/ulp_host.sv
// host processor model on the register port
`default_nettype none
module ulp_host (
  // clock
  input wire logic clk_in,
  // register port
  input wire logic [ulp_pkg::DATA_W-1:0] rdata_in,
  output var ulp_pkg::ulp_req_s bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_out = '0;
  // an idle edge between accesses keeps each strobe a single pulse
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_out <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_out <= '0;
    @(posedge clk_in);
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ### bench/uart_low_power_control_tb.sv
// self-checking bench for the uart low-power controller
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
`define WT(c) begin n = 0; while (!(c) && n < 400) begin @(posedge clk_in); n++; end \
  `CHK((c), 1'b1) end
module uart_low_power_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_in = 1, aps = 0, iso = 0, pend = 0, txa = 0, ce = 1;
  logic [1:0] rx = 2'b11;
  logic [2:0] osr = 3'h0;
  logic [3:0] modem = 4'h0, code = 4'h0;
  logic [7:0] rdata, d, divh;
  logic crys, hold, irq, pon, prdy, drv, isod, slp;
  ulp_pkg::ulp_req_s bus;
  int err_count = 0, comparisons = 0, n, cyc = 0, b;
  always #4 clk_in = ~clk_in;
  // oscillator needs a few cycles to come up after restart
  always @(posedge clk_in) osr <= {osr[1:0], crys};
  ulp_top #(.IDLE_CYCLES(32'd50), .PUMP_CYCLES(16'd8), .OSC_CYCLES(16'd4)) uut (
    .clk_in, .rst_in, .ce_in(ce), .bus_in(bus), .rdata_out(rdata), .irq_out(irq),
    .rx_in(rx), .modem_in(modem), .auto_pump_shutdown_pin_in(aps), .bus_isolate_pin_in(iso),
    .osc_ready_in(osr[2]), .crystal_out_pin_en_out(crys), .core_hold_out(hold),
    .tx_active_in(txa), .uart_int_pending_in(pend), .uart_int_code_in(code),
    .pump_on_out(pon), .pump_ready_out(prdy), .rs485_drv_en_out(drv),
    .bus_isolated_out(isod), .sleeping_out(slp));
  ulp_host host (.clk_in, .rdata_in(rdata), .bus_out(bus));
  function automatic logic [7:0] pwr(input logic w, r, o, i, s);
    return {3'h0, w, r, o, i, s};
  endfunction
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // wake service: source read, then the modem read that rearms sleep
  task automatic svc(input logic [3:0] dl);
    `WT(slp === 1'b0)
    `WT(hold === 1'b0)
    `CHK(slp, 1'b0)
    host.rd(ulp_pkg::A_INTSRC, d);
    `CHK(d[3:0], ulp_pkg::WAKE_CODE)
    host.rd(ulp_pkg::A_MDMST, d);
    `CHK(d[3:0], dl)
    `WT(slp === 1'b1)
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(56421));
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    host.rd(ulp_pkg::A_PWR, d);
    `CHK(d, pwr(0, 1, 1, 0, 0))
    host.rd(ulp_pkg::A_INTEN, d);
    `CHK(d, ulp_pkg::INTEN_RST)
    pend <= 1'b1;
    code <= 4'($urandom_range(15, 2));
    host.wr(ulp_pkg::A_INTEN, 8'h10);
    repeat (20) @(posedge clk_in);
    `CHK(slp, 1'b0)
    divh = 8'($urandom_range(255, 1));
    host.wr(ulp_pkg::A_DIVH, divh);
    host.rd(ulp_pkg::A_INTSRC, d);
    `CHK(d[3:0], code)
    `CHK(slp, 1'b0)
    pend <= 1'b0;
    `WT(slp === 1'b1)
    `CHK(crys, 1'b0)
    `CHK(irq, 1'b0)
    host.wr(ulp_pkg::A_MASK, 8'h1f);
    `WT(irq === 1'b1)
    host.rd(ulp_pkg::A_EVT, d);
    `CHK(d, 8'(1 << ulp_pkg::EV_SLEEP))
    host.rd(ulp_pkg::A_MASK, d);
    `CHK(d, 8'h1f)
    host.wr(ulp_pkg::A_EVT, 8'h1f);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b0)
    host.wr(ulp_pkg::A_TXH, 8'($urandom));
    svc(4'h0);
    for (b = 0; b < 4; b++) begin
      modem[b] <= 1'b1;
      svc(4'h1 << b);
      modem[b] <= 1'b0;
      svc(4'h1 << b);
    end
    b = $urandom_range(1, 0);
    rx[b] <= 1'b0;
    repeat (4) @(posedge clk_in);
    rx[b] <= 1'b1;
    svc(4'h0);
    aps <= 1'b1;
    `WT(pon === 1'b0)
    `CHK(drv, 1'b0)
    host.rd(ulp_pkg::A_PWR, d);
    `CHK(d, pwr(0, 0, 0, 0, 1))
    host.rd(ulp_pkg::A_DIVH, d);
    `CHK(d, divh)
    host.wr(ulp_pkg::A_TXH, 8'h3c);
    `WT(pon === 1'b1)
    svc(4'h0);
    host.wr(ulp_pkg::A_INTEN, 8'h00);
    `WT(hold === 1'b0)
    host.wr(ulp_pkg::A_TXH, 8'h81);
    `WT(prdy === 1'b1)
    txa <= 1'b1;
    repeat (100) @(posedge clk_in);
    `CHK(prdy, 1'b1)
    txa <= 1'b0;
    repeat (40) @(posedge clk_in);
    `CHK(pon, 1'b1)
    `WT(pon === 1'b0)
    `CHK(slp, 1'b0)
    modem[0] <= 1'b1;
    `WT(pon === 1'b1)
    aps <= 1'b0;
    iso <= 1'b1;
    host.rd(ulp_pkg::A_MDMST, d);
    host.wr(ulp_pkg::A_INTEN, 8'h10);
    `WT(isod === 1'b1)
    host.wr(ulp_pkg::A_TXH, 8'h5a);
    repeat (4) @(posedge clk_in);
    `CHK(slp, 1'b1)
    modem[0] <= 1'b0;
    svc(4'h1);
    `WT(isod === 1'b1)
    iso <= 1'b0;
    `WT(isod === 1'b0)
    `CHK(slp, 1'b1)
    // a frozen clock enable drops the disable write, so sleep must persist
    ce <= 1'b0;
    host.wr(ulp_pkg::A_INTEN, 8'h00);
    repeat (4) @(posedge clk_in);
    `CHK(slp, 1'b1)
    ce <= 1'b1;
    repeat (2) @(posedge clk_in);
    `CHK(slp, 1'b1)
    host.wr(ulp_pkg::A_INTEN, 8'h00);
    `WT(slp === 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
